/* src/tis_regs.vh */
`ifndef TIS_REGS_VH
`define TIS_REGS_VH

// register byte offsets
`define TIS_OFS_STATUS     8'h20
`define TIS_OFS_IRQ_EN     8'h24
`define TIS_OFS_IRQ_DIS    8'h28
`define TIS_OFS_IRQ_MASK   8'h2C
`define TIS_OFS_RX_HOLD    8'h30
`define TIS_OFS_TX_HOLD    8'h34
`define TIS_OFS_IRQ_PEND   8'h38
`define TIS_OFS_IRQ_CLR    8'h3C

// status / interrupt bit positions
`define TIS_BIT_TRANSFER_DONE_FLAG     0
`define TIS_BIT_RX_BYTE_READY_FLAG      1
`define TIS_BIT_TX_HOLDING_EMPTY_FLAG      2
`define TIS_BIT_SVREAD     3
`define TIS_BIT_SLAVE_SELECTED_FLAG      4
`define TIS_BIT_GCALL      5
`define TIS_BIT_OVRUN      6
`define TIS_BIT_NACK       8
`define TIS_BIT_ARBLOST    9
`define TIS_BIT_CLKWAIT    10
`define TIS_BIT_SVEND      11

// widths and reset values
`define TIS_FLAG_W         12
`define TIS_IRQ_VALID      12'hF77
`define TIS_MASK_RESET     12'h000
`define TIS_BYTE_RESET     8'h00

`endif

/* src/tis_irq_mask.v */
`timescale 1ns/1ns
`default_nettype none

`include "tis_regs.vh"

// interrupt mask, sticky pending bits and the single level interrupt
module tis_irq_mask #(
    parameter W = `TIS_FLAG_W
) (
    // clock and reset
    input  wire         clk,
    input  wire         reset_n,
    // register writes, one-cycle strobes
    input  wire         en_we,
    input  wire         dis_we,
    input  wire         clr_we,
    input  wire [W-1:0] wdata,
    // live status flags
    input  wire [W-1:0] status,
    // results
    output reg  [W-1:0] mask_q,
    output reg  [W-1:0] pend_q,
    output reg          irq_q
);

    reg [W-1:0] mask_d;
    reg [W-1:0] pend_d;

    always @* begin
        mask_d = mask_q;
        if (en_we) begin
            mask_d = mask_d | (wdata & `TIS_IRQ_VALID); // [RULE_05]
        end
        if (dis_we) begin
            mask_d = mask_d & ~wdata; // [RULE_06]
        end
        pend_d = pend_q;
        if (clr_we) begin
            pend_d = pend_d & ~wdata;
        end
        // a flag high in the clearing cycle is kept
        pend_d = pend_d | (status & `TIS_IRQ_VALID);
    end

    always @(posedge clk) begin
        if (!reset_n) begin
            mask_q <= `TIS_MASK_RESET; // [RULE_07]
            pend_q <= {W{1'b0}};
            irq_q  <= 1'b0;
        end else begin
            mask_q <= mask_d;
            pend_q <= pend_d;
            irq_q  <= |((pend_d | status) & mask_d); // [RULE_14]
        end
    end

endmodule // tis_irq_mask

`default_nettype wire

/* src/tis_core.v */
// The Avalon-MM slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

`include "tis_regs.vh"

// Summary of operation
// [RULE_01] clock wait flag follows stretching, slave only
// [RULE_02] stretch when holding byte not ready
// [RULE_03] slave end flag set as access ends
// [RULE_04] status read clears slave end flag
// [RULE_05] enable write sets written mask bits
// [RULE_06] disable write clears written mask bits
// [RULE_07] mask reads enabled sources, resets zero
// [RULE_08] low byte interrupt bit positions fixed
// [RULE_09] upper interrupt bits eight to eleven
// [RULE_10] receive holding shows last byte received
// [RULE_11] transmit holding takes next byte, resets zero
// [RULE_12] slave selected follows address match until stop
// [RULE_13] arbitration lost set with done, read clears
// [RULE_14] interrupt while flag and mask both set
module tis_core #(
    parameter AW = 8,
    parameter DW = 32
) (
    // clock and reset
    input  wire          clk,
    input  wire          reset_n,
    // avalon-mm slave
    input  wire [AW-1:0] avs_address,
    input  wire          avs_read,
    input  wire          avs_write,
    input  wire [DW-1:0] avs_writedata,
    input  wire [3:0]    avs_byteenable,
    output reg  [DW-1:0] avs_readdata,
    output reg           avs_waitrequest,
    // serial engine status
    input  wire          slave_mode,
    input  wire          slave_selected_flag,
    input  wire          slave_read_dir,
    input  wire          transfer_done_flag,
    input  wire          general_call_evt,
    input  wire          nack_evt,
    input  wire          arb_lost_evt,
    // serial engine byte handoff
    input  wire          rx_byte_valid,
    input  wire [7:0]    rx_byte,
    input  wire          tx_byte_need,
    output reg           rx_byte_taken,
    output reg           tx_byte_load,
    output reg  [7:0]    tx_byte,
    // serial clock hold and interrupt
    output reg           scl_stretch,
    output reg           irq
);

    // register decode, used by read and write paths
    function [3:0] reg_index;
        input [AW-1:0] addr;
        begin
            case (addr)
                `TIS_OFS_STATUS:   reg_index = 4'h1;
                `TIS_OFS_IRQ_EN:   reg_index = 4'h2;
                `TIS_OFS_IRQ_DIS:  reg_index = 4'h3;
                `TIS_OFS_IRQ_MASK: reg_index = 4'h4;
                `TIS_OFS_RX_HOLD:  reg_index = 4'h5;
                `TIS_OFS_TX_HOLD:  reg_index = 4'h6;
                `TIS_OFS_IRQ_PEND: reg_index = 4'h7;
                `TIS_OFS_IRQ_CLR:  reg_index = 4'h8;
                default:           reg_index = 4'h0;
            endcase
        end
    endfunction

    localparam [3:0] IX_STATUS = 4'h1;
    localparam [3:0] IX_EN     = 4'h2;
    localparam [3:0] IX_DIS    = 4'h3;
    localparam [3:0] IX_MASK   = 4'h4;
    localparam [3:0] IX_RHR    = 4'h5;
    localparam [3:0] IX_THR    = 4'h6;
    localparam [3:0] IX_PEND   = 4'h7;
    localparam [3:0] IX_CLR    = 4'h8;

    localparam FW = `TIS_FLAG_W;

    // bus handshake state
    reg          wait_q;
    reg  [DW-1:0] rdata_d;

    // held flags
    reg          rx_byte_ready_flag_q;
    reg          tx_holding_empty_flag_q;
    reg          gcall_q;
    reg          ovrun_q;
    reg          nack_q;
    reg          arblost_q;
    reg          clkwait_q;
    reg          svend_q;
    reg          slave_selected_flag_q;
    reg  [7:0]   rhr_q;
    reg  [7:0]   thr_q;

    reg          rx_byte_ready_flag_d;
    reg          tx_holding_empty_flag_d;
    reg          gcall_d;
    reg          ovrun_d;
    reg          nack_d;
    reg          arblost_d;
    reg          clkwait_d;
    reg          svend_d;
    reg  [7:0]   rhr_d;
    reg  [7:0]   thr_d;

    wire [3:0]   idx;
    wire         acc_done;
    wire         rd_done;
    wire         wr_done;
    wire         st_read;
    wire         thr_write;
    wire         rhr_read;
    wire         rx_accept;
    wire         tx_accept;
    wire [FW-1:0] status_w;
    wire [FW-1:0] mask_w;
    wire [FW-1:0] pend_w;
    wire         irq_w;
    wire [FW-1:0] wbits;

    assign idx      = reg_index(avs_address);
    // access completes at the edge where waitrequest is seen low
    assign acc_done = ~wait_q;
    assign rd_done  = acc_done & avs_read;
    assign wr_done  = acc_done & avs_write;
    assign st_read  = rd_done & (idx == IX_STATUS);
    assign rhr_read = rd_done & (idx == IX_RHR);
    assign thr_write = wr_done & (idx == IX_THR) & avs_byteenable[0];
    assign wbits    = {avs_byteenable[1] ? avs_writedata[FW-1:8] : 4'h0,
                       avs_byteenable[0] ? avs_writedata[7:0] : 8'h00};

    // slave mode stalls a byte while the holding register is still full
    assign rx_accept = rx_byte_valid & ~(slave_mode & rx_byte_ready_flag_q); // [RULE_02]
    assign tx_accept = tx_byte_need & ~tx_holding_empty_flag_q;

    assign status_w = {svend_q,                  // [RULE_09]
                       clkwait_q,
                       arblost_q,
                       nack_q,
                       1'b0,                     // [RULE_08]
                       ovrun_q,
                       gcall_q,
                       slave_selected_flag_q,
                       slave_read_dir & slave_selected_flag_q,
                       tx_holding_empty_flag_q,
                       rx_byte_ready_flag_q,
                       transfer_done_flag};

    tis_irq_mask #(
        .W (FW)
    ) u_irq (
        .clk     (clk),
        .reset_n (reset_n),
        .en_we   (wr_done & (idx == IX_EN)),
        .dis_we  (wr_done & (idx == IX_DIS)),
        .clr_we  (wr_done & (idx == IX_CLR)),
        .wdata   (wbits),
        .status  (status_w),
        .mask_q  (mask_w),
        .pend_q  (pend_w),
        .irq_q   (irq_w)
    );

    // flag next values; every hardware set wins over a read clear
    always @* begin
        rx_byte_ready_flag_d   = rx_byte_ready_flag_q;
        tx_holding_empty_flag_d   = tx_holding_empty_flag_q;
        gcall_d   = gcall_q;
        ovrun_d   = ovrun_q;
        nack_d    = nack_q;
        arblost_d = arblost_q;
        svend_d   = svend_q;
        rhr_d     = rhr_q;
        thr_d     = thr_q;

        if (rhr_read) begin
            rx_byte_ready_flag_d = 1'b0;
        end
        if (st_read) begin
            gcall_d   = 1'b0;
            nack_d    = 1'b0;
            arblost_d = 1'b0; // [RULE_13]
            svend_d   = 1'b0; // [RULE_04]
            if (transfer_done_flag) begin
                ovrun_d = 1'b0;
            end
        end
        if (thr_write) begin
            thr_d   = avs_writedata[7:0]; // [RULE_11]
            tx_holding_empty_flag_d = 1'b0;
        end

        if (rx_accept) begin
            rhr_d   = rx_byte; // [RULE_10]
            rx_byte_ready_flag_d = 1'b1;
            if (rx_byte_ready_flag_q & ~rhr_read) begin
                ovrun_d = 1'b1;
            end
        end
        if (tx_accept | nack_evt) begin
            tx_holding_empty_flag_d = 1'b1;
        end
        if (general_call_evt & slave_mode) begin
            gcall_d = 1'b1;
        end
        if (nack_evt) begin
            nack_d = 1'b1;
        end
        if (arb_lost_evt & ~slave_mode) begin
            arblost_d = 1'b1; // [RULE_13]
        end
        // access end: selected flag falling
        if (slave_mode & slave_selected_flag_q & ~slave_selected_flag) begin
            svend_d = 1'b1; // [RULE_03]
        end
        // flag low while an access is running
        if (slave_mode & slave_selected_flag) begin
            svend_d = 1'b0; // [RULE_03]
        end

        // stretch while a byte waits on a full or empty holding register
        clkwait_d = slave_mode & slave_selected_flag &
                    ((tx_byte_need & tx_holding_empty_flag_d) |
                     (rx_byte_valid & rx_byte_ready_flag_q & ~rhr_read)); // [RULE_01] [RULE_02]
    end

    always @(posedge clk) begin
        if (!reset_n) begin
            rx_byte_ready_flag_q   <= 1'b0;
            tx_holding_empty_flag_q   <= 1'b0;
            gcall_q   <= 1'b0;
            ovrun_q   <= 1'b0;
            nack_q    <= 1'b0;
            arblost_q <= 1'b0;
            clkwait_q <= 1'b0;
            svend_q   <= 1'b0;
            slave_selected_flag_q   <= 1'b0;
            rhr_q     <= `TIS_BYTE_RESET;
            thr_q     <= `TIS_BYTE_RESET;
        end else begin
            rx_byte_ready_flag_q   <= rx_byte_ready_flag_d;
            tx_holding_empty_flag_q   <= tx_holding_empty_flag_d;
            gcall_q   <= gcall_d;
            ovrun_q   <= ovrun_d;
            nack_q    <= nack_d;
            arblost_q <= arblost_d;
            clkwait_q <= clkwait_d; // [RULE_01]
            svend_q   <= svend_d;
            slave_selected_flag_q   <= slave_mode & slave_selected_flag; // [RULE_12]
            rhr_q     <= rhr_d;
            thr_q     <= thr_d;
        end
    end

    // read mux, sampled at the edge where waitrequest falls
    always @* begin
        rdata_d = {DW{1'b0}};
        case (idx)
            IX_STATUS: rdata_d[FW-1:0] = status_w;
            IX_MASK:   rdata_d[FW-1:0] = mask_w; // [RULE_07]
            IX_RHR:    rdata_d[7:0]    = rhr_q;  // [RULE_10]
            IX_THR:    rdata_d[7:0]    = thr_q;
            IX_PEND:   rdata_d[FW-1:0] = pend_w;
            default:   rdata_d = {DW{1'b0}};
        endcase
    end

    // bus handshake and registered outputs
    always @(posedge clk) begin
        if (!reset_n) begin
            wait_q          <= 1'b1;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= {DW{1'b0}};
            rx_byte_taken   <= 1'b0;
            tx_byte_load    <= 1'b0;
            tx_byte         <= `TIS_BYTE_RESET;
            scl_stretch     <= 1'b0;
            irq             <= 1'b0;
        end else begin
            if (wait_q & (avs_read | avs_write)) begin
                wait_q          <= 1'b0;
                avs_waitrequest <= 1'b0;
                avs_readdata    <= avs_read ? rdata_d : {DW{1'b0}};
            end else begin
                wait_q          <= 1'b1;
                avs_waitrequest <= 1'b1;
            end
            rx_byte_taken <= rx_accept;
            tx_byte_load  <= tx_accept;
            if (tx_accept) begin
                tx_byte <= thr_q; // [RULE_11]
            end
            scl_stretch   <= clkwait_d; // [RULE_02]
            irq           <= irq_w;     // [RULE_14]
        end
    end

endmodule // tis_core

`default_nettype wire

/* verif/tis_core_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module tis_core_chk (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // bus handshake
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    // engine side
    input wire logic slave_mode,
    input wire logic slave_selected_flag,
    input wire logic rx_byte_valid,
    input wire logic rx_byte_taken,
    input wire logic tx_byte_need,
    input wire logic tx_byte_load,
    input wire logic scl_stretch,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence req_s;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence rx_stall_s;
        (slave_mode && slave_selected_flag && rx_byte_valid && !rx_byte_taken) [*3];
    endsequence
    sequence tx_stall_s;
        (slave_mode && slave_selected_flag && tx_byte_need && !tx_byte_load) [*3];
    endsequence
    wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    bus_answer_a: assert property (req_s |=> !avs_waitrequest)
        else $error("request not answered");
    answer_cause_a: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
        else $error("answer without request");
    rx_stretch_a: assert property (
        rx_stall_s |-> ##[0:2] (scl_stretch || rx_byte_taken))
        else $error("rx stall without stretch");
    tx_stretch_a: assert property (
        tx_stall_s |-> ##[0:2] (scl_stretch || tx_byte_load))
        else $error("tx stall without stretch");
    stretch_slave_a: assert property (!slave_mode [*3] |-> !scl_stretch)
        else $error("stretch outside slave mode");
    tx_load_a: assert property (
        $rose(tx_byte_load) |-> $past(tx_byte_need) ##1 !tx_byte_load)
        else $error("bad tx load pulse");
    rx_take_a: assert property (rx_byte_taken |-> $past(rx_byte_valid))
        else $error("rx taken without offer");
    reset_quiet_a: assert property (
        disable iff (1'b0) !reset_n |=> avs_waitrequest && !irq)
        else $error("outputs active after reset");
endmodule // tis_core_chk

bind tis_core tis_core_chk u_chk (
    .clk(clk), .reset_n(reset_n), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .slave_mode(slave_mode),
    .slave_selected_flag(slave_selected_flag),
    .rx_byte_valid(rx_byte_valid), .rx_byte_taken(rx_byte_taken),
    .tx_byte_need(tx_byte_need), .tx_byte_load(tx_byte_load),
    .scl_stretch(scl_stretch), .irq(irq)
);
`default_nettype wire

/* verif/tis_core_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "tis_regs.vh"
module tis_core_tb;
    logic        clk, reset_n, avs_read, avs_write, avs_waitrequest, e;
    logic [7:0]  avs_address, rx_byte, tx_byte, b;
    logic [31:0] avs_writedata, avs_readdata, q, w;
    logic [3:0]  avs_byteenable;
    logic        slave_mode, slave_selected_flag, slave_read_dir, transfer_done_flag;
    logic        rx_byte_valid, rx_byte_taken, tx_byte_need, tx_byte_load, scl_stretch, irq;
    logic [2:0]  evt;
    logic [11:0] m;
    int          fail_count, compares;
    int          evbit[3] = '{`TIS_BIT_GCALL, `TIS_BIT_NACK, `TIS_BIT_ARBLOST};

    tis_core uut (
        .clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .irq(irq),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .slave_mode(slave_mode),
        .slave_selected_flag(slave_selected_flag), .slave_read_dir(slave_read_dir),
        .transfer_done_flag(transfer_done_flag), .general_call_evt(evt[0]),
        .nack_evt(evt[1]), .arb_lost_evt(evt[2]), .rx_byte_valid(rx_byte_valid),
        .rx_byte(rx_byte), .tx_byte_need(tx_byte_need), .rx_byte_taken(rx_byte_taken),
        .tx_byte_load(tx_byte_load), .tx_byte(tx_byte), .scl_stretch(scl_stretch)
    );

    function automatic logic [11:0] next_mask(logic [11:0] o, logic en, logic [31:0] v);
        return en ? (o | (v[11:0] & `TIS_IRQ_VALID)) : (o & ~v[11:0]);
    endfunction

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        chk("waitrequest", 32'h0, avs_waitrequest);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // read status and check one bit
    task automatic stat(input int p, input logic x);
        bus(1'b0, `TIS_OFS_STATUS, 32'h0);
        chk("status", x, q[p]);
    endtask

    // k selects tx load or rx taken
    task automatic wait_hi(input logic k);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while ((k ? tx_byte_load : rx_byte_taken) !== 1'b1 && n < 20);
        chk("handshake", 32'h1, k ? tx_byte_load : rx_byte_taken);
    endtask

    task automatic rx_put(input logic [7:0] v, input logic hold);
        @(posedge clk);
        rx_byte <= v;
        rx_byte_valid <= 1'b1;
        @(posedge clk);
        if (!hold) begin
            rx_byte_valid <= 1'b0;
            wait_hi(1'b0);
        end
    endtask

    task automatic print_verdict;
        if (fail_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        print_verdict;
    end

    initial begin
        {reset_n, avs_read, avs_write, slave_mode, slave_selected_flag, e} = '0;
        {slave_read_dir, transfer_done_flag, rx_byte_valid, tx_byte_need} = '0;
        {avs_address, rx_byte, avs_writedata, evt, m} = '0;
        avs_byteenable = 4'hF;
        fail_count = 0;
        compares = 0;
        void'($urandom(32'h2B2B));
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        bus(1'b0, `TIS_OFS_IRQ_MASK, 32'h0);
        chk("irq_mask", 32'h0, q);
        bus(1'b0, `TIS_OFS_TX_HOLD, 32'h0);
        chk("tx_holding", 32'h0, q);
        bus(1'b0, 8'h00, 32'h0);
        chk("unmapped", 32'h0, q);
        repeat (24) begin
            w = $urandom;
            e = w[31];
            bus(1'b1, e ? `TIS_OFS_IRQ_EN : `TIS_OFS_IRQ_DIS, w);
            m = next_mask(m, e, w);
            bus(1'b0, `TIS_OFS_IRQ_MASK, w);
            chk("irq_mask", {20'h0, m}, q);
        end
        bus(1'b1, `TIS_OFS_IRQ_DIS, 32'hFFF);
        bus(1'b1, `TIS_OFS_IRQ_CLR, 32'hFFF);
        w = $urandom;
        bus(1'b1, `TIS_OFS_TX_HOLD, w);
        bus(1'b0, `TIS_OFS_TX_HOLD, 32'h0);
        chk("tx_holding", {24'h0, w[7:0]}, q);
        tx_byte_need <= 1'b1;
        wait_hi(1'b1);
        tx_byte_need <= 1'b0;
        chk("tx_byte", w[7:0], tx_byte);
        @(posedge clk);
        tx_byte_need <= 1'b1;
        repeat (5) @(posedge clk);
        chk("scl_stretch", 32'h0, scl_stretch);
        slave_mode <= 1'b1;
        slave_selected_flag <= 1'b1;
        repeat (5) @(posedge clk);
        chk("scl_stretch", 32'h1, scl_stretch);
        stat(`TIS_BIT_CLKWAIT, 1'b1);
        w = $urandom;
        bus(1'b1, `TIS_OFS_TX_HOLD, w);
        wait_hi(1'b1);
        tx_byte_need <= 1'b0;
        chk("tx_byte", w[7:0], tx_byte);
        repeat (3) @(posedge clk);
        chk("scl_stretch", 32'h0, scl_stretch);
        b = $urandom;
        rx_put(b, 1'b0);
        bus(1'b0, `TIS_OFS_RX_HOLD, 32'h0);
        chk("rx_holding", {24'h0, b}, q);
        b = $urandom;
        rx_put(b, 1'b0);
        w = $urandom;
        rx_put(w[7:0], 1'b1);
        repeat (4) @(posedge clk);
        chk("scl_stretch", 32'h1, scl_stretch);
        bus(1'b0, `TIS_OFS_RX_HOLD, 32'h0);
        chk("rx_holding", {24'h0, b}, q);
        wait_hi(1'b0);
        rx_byte_valid <= 1'b0;
        bus(1'b0, `TIS_OFS_RX_HOLD, 32'h0);
        chk("rx_holding", {24'h0, w[7:0]}, q);
        bus(1'b1, `TIS_OFS_IRQ_EN, 32'h800);
        slave_selected_flag <= 1'b1;
        stat(`TIS_BIT_SLAVE_SELECTED_FLAG, 1'b1);
        stat(`TIS_BIT_SVEND, 1'b0);
        chk("irq", 32'h0, irq);
        slave_selected_flag <= 1'b0;
        repeat (4) @(posedge clk);
        chk("irq", 32'h1, irq);
        stat(`TIS_BIT_SVEND, 1'b1);
        stat(`TIS_BIT_SVEND, 1'b0);
        bus(1'b1, `TIS_OFS_IRQ_CLR, 32'h800);
        repeat (2) @(posedge clk);
        chk("irq", 32'h0, irq);
        for (int i = 0; i < 3; i++) begin
            slave_mode <= (i == 0);
            transfer_done_flag <= 1'b1;
            evt <= 3'h1 << i;
            @(posedge clk);
            evt <= 3'h0;
            stat(evbit[i], 1'b1);
            chk("done", 32'h1, q[`TIS_BIT_TRANSFER_DONE_FLAG]);
            stat(evbit[i], 1'b0);
        end
        // master receive over a full holding register
        b = $urandom;
        rx_put(b, 1'b0);
        b = $urandom;
        rx_put(b, 1'b0);
        stat(`TIS_BIT_OVRUN, 1'b1);
        stat(`TIS_BIT_OVRUN, 1'b0);
        bus(1'b0, `TIS_OFS_RX_HOLD, 32'h0);
        chk("rx_holding", {24'h0, b}, q);
        print_verdict;
    end
endmodule // tis_core_tb
`default_nettype wire
